/* common/pfc_pkg.sv */
package pfc_pkg;

    // ****************************************************************
    // Register offsets (byte addresses, one word each)
    // ****************************************************************
    localparam logic [7:0] PFC_OFS_CTRL = 8'h00;
    localparam logic [7:0] PFC_OFS_STATUS = 8'h04;
    localparam logic [7:0] PFC_OFS_PC = 8'h08;
    localparam logic [7:0] PFC_OFS_STK = 8'h0C;
    localparam logic [7:0] PFC_OFS_PAIR = 8'h10;
    localparam logic [7:0] PFC_OFS_FLAGS = 8'h14;
    localparam logic [7:0] PFC_OFS_OPCODE = 8'h18;
    localparam logic [7:0] PFC_OFS_COUNT = 8'h1C;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int PFC_CTRL_RUN_BIT = 0;
    localparam int PFC_CTRL_STEP_BIT = 1;
    localparam int PFC_CTRL_CLR_BIT = 2;
    localparam int PFC_STAT_BUSY_BIT = 0;
    localparam int PFC_STAT_ILLEGAL_BIT = 1;
    localparam int PFC_STAT_STATE_LSB = 4;
    localparam int PFC_PAIR_H_LSB = 8;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] PFC_PC_RESET = 16'h0000;
    localparam logic [15:0] PFC_STK_RESET = 16'h0000;
    localparam logic [7:0] PFC_BYTE_RESET = 8'h00;
    localparam logic [3:0] PFC_FLAGS_RESET = 4'h0;

    // ****************************************************************
    // Opcode encodings
    // ****************************************************************
    localparam logic [7:0] PFC_OP_COND_MASK = 8'hC7;
    localparam logic [7:0] PFC_OP_BRANCH_COND = 8'hC2;
    localparam logic [7:0] PFC_OP_CALL_COND = 8'hC4;
    localparam logic [7:0] PFC_OP_RETURN_COND = 8'hC0;
    localparam logic [7:0] PFC_OP_BRANCH_ALWAYS = 8'hC3;
    localparam logic [7:0] PFC_OP_CALL_ALWAYS = 8'hCD;
    localparam logic [7:0] PFC_OP_RETURN_ALWAYS = 8'hC9;
    localparam logic [7:0] PFC_OP_PAIR_TO_COUNTER = 8'hE9;
    localparam logic [7:0] PFC_OP_LOAD_PAIR = 8'h2A;
    localparam logic [7:0] PFC_OP_STORE_PAIR = 8'h22;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic parity;
        logic sign;
        logic zero;
        logic carry;
    } pfc_flags_s;

    typedef enum logic [2:0] {
        KIND_ILLEGAL = 3'b000,
        KIND_JUMP = 3'b001,
        KIND_CALL = 3'b010,
        KIND_RETURN = 3'b011,
        KIND_PAIR_JUMP = 3'b100,
        KIND_LOAD_PAIR = 3'b101,
        KIND_STORE_PAIR = 3'b110
    } pfc_kind_e;

    typedef struct packed {
        pfc_kind_e kind;
        logic taken;
        logic operand;
    } pfc_dec_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_OPCODE = 4'b0001,
        ST_DECODE = 4'b0010,
        ST_ADDR_LO = 4'b0011,
        ST_ADDR_HI = 4'b0100,
        ST_EXEC = 4'b0101,
        ST_PUSH_HI = 4'b0110,
        ST_PUSH_LO = 4'b0111,
        ST_POP_LO = 4'b1000,
        ST_POP_HI = 4'b1001,
        ST_DATA_LO = 4'b1010,
        ST_DATA_HI = 4'b1011
    } pfc_state_e;

    // Bits 2:1 of the condition field pick the flag, bit 0 the polarity.
    function automatic logic pfc_cond_met(input logic [2:0] cond, input pfc_flags_s fl);
        logic sel;
        sel = 1'b0;
        unique case (cond[2:1])
            2'b00: sel = fl.zero;
            2'b01: sel = fl.carry;
            2'b10: sel = fl.parity;
            2'b11: sel = fl.sign;
        endcase
        return sel == cond[0];
    endfunction

endpackage

/* verilog/pfc_decode.sv */
`timescale 1ns/100ps
module pfc_decode
    import pfc_pkg::*;
(
    input wire logic [7:0] opcode,
    input wire pfc_flags_s flags,
    output pfc_dec_s dec
);

    // ****************************************************************
    // Opcode classes
    // ****************************************************************
    wire logic is_branch_cond = (opcode & PFC_OP_COND_MASK) == PFC_OP_BRANCH_COND;
    wire logic is_call_cond = (opcode & PFC_OP_COND_MASK) == PFC_OP_CALL_COND;
    wire logic is_return_cond = (opcode & PFC_OP_COND_MASK) == PFC_OP_RETURN_COND;
    wire logic is_branch = (opcode == PFC_OP_BRANCH_ALWAYS) || is_branch_cond;
    wire logic is_call = (opcode == PFC_OP_CALL_ALWAYS) || is_call_cond;
    wire logic is_return = (opcode == PFC_OP_RETURN_ALWAYS) || is_return_cond;
    wire logic is_pair_jump = opcode == PFC_OP_PAIR_TO_COUNTER;
    wire logic is_load = opcode == PFC_OP_LOAD_PAIR;
    wire logic is_store = opcode == PFC_OP_STORE_PAIR;
    wire logic is_cond = is_branch_cond || is_call_cond || is_return_cond;
    wire logic cond_ok = pfc_cond_met(opcode[5:3], flags);

    // ****************************************************************
    // Result
    // ****************************************************************
    wire pfc_kind_e kind = is_branch ? KIND_JUMP :
                           is_call ? KIND_CALL :
                           is_return ? KIND_RETURN :
                           is_pair_jump ? KIND_PAIR_JUMP :
                           is_load ? KIND_LOAD_PAIR :
                           is_store ? KIND_STORE_PAIR : KIND_ILLEGAL;

    assign dec.kind = kind;
    assign dec.taken = is_cond ? cond_ok : 1'b1;
    assign dec.operand = is_branch || is_call || is_load || is_store;

endmodule // pfc_decode

/* verilog/pfc_top.sv */
`timescale 1ns/100ps
module pfc_top
    import pfc_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [15:0] MEM_ADDR,
    output logic [7:0] MEM_WDATA,
    output logic MEM_WRITE,
    output logic MEM_REQ,
    input wire logic [7:0] MEM_RDATA,
    input wire logic MEM_ACK
);

    // ****************************************************************
    // Architectural state
    // ****************************************************************
    logic [15:0] pc;
    logic [15:0] stk;
    logic [15:0] tgt;
    logic [7:0] reg_h;
    logic [7:0] reg_l;
    logic [7:0] opcode;
    logic [31:0] count;
    logic run;
    logic illegal;
    pfc_flags_s flags;
    pfc_state_e state;
    pfc_dec_s dec;

    pfc_decode u_decode (
        .opcode(opcode),
        .flags(flags),
        .dec(dec)
    );

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire logic idle = state == ST_IDLE;
    wire logic apb_setup = PSEL & ~PENABLE;
    wire logic apb_write = PSEL & PENABLE & PWRITE & PREADY & ~PSLVERR;
    wire logic hit_ctrl = PADDR == PFC_OFS_CTRL;
    wire logic hit_status = PADDR == PFC_OFS_STATUS;
    wire logic hit_pc = PADDR == PFC_OFS_PC;
    wire logic hit_stk = PADDR == PFC_OFS_STK;
    wire logic hit_pair = PADDR == PFC_OFS_PAIR;
    wire logic hit_flags = PADDR == PFC_OFS_FLAGS;
    wire logic hit_opcode = PADDR == PFC_OFS_OPCODE;
    wire logic hit_count = PADDR == PFC_OFS_COUNT;
    wire logic hit_arch = hit_pc | hit_stk | hit_pair | hit_flags;
    wire logic hit_ro = hit_status | hit_opcode | hit_count;
    wire logic hit_any = hit_ctrl | hit_arch | hit_ro;
    // Core state may only be rewritten while the core is stopped, so a
    // write never races an instruction in flight.
    wire logic next_slverr = ~hit_any | (PWRITE & (hit_ro | (hit_arch & ~idle)));
    wire logic ctrl_write = apb_write & hit_ctrl;
    wire logic step_req = ctrl_write & PWDATA[PFC_CTRL_STEP_BIT];
    wire logic clr_req = ctrl_write & PWDATA[PFC_CTRL_CLR_BIT];
    wire logic start = idle & (run | step_req);

    wire logic [31:0] status_word = {24'h000000, state, 2'b00, illegal, ~idle};
    wire logic [31:0] next_prdata =
        hit_ctrl ? {31'h00000000, run} :
        hit_status ? status_word :
        hit_pc ? {16'h0000, pc} :
        hit_stk ? {16'h0000, stk} :
        hit_pair ? {16'h0000, reg_h, reg_l} :
        hit_flags ? {28'h0000000, flags} :
        hit_opcode ? {24'h000000, opcode} :
        hit_count ? count : 32'h00000000;

    // ****************************************************************
    // APB answer
    // ****************************************************************
    // The answer is prepared in the setup cycle so that every bus output
    // comes from a flip-flop and the access still needs no wait state.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end else begin
            PREADY <= apb_setup;
            PSLVERR <= apb_setup & next_slverr;
            PRDATA <= (apb_setup & ~PWRITE & hit_any) ? next_prdata : 32'h00000000;
        end
    end

    // ****************************************************************
    // Memory access per state
    // ****************************************************************
    logic [15:0] acc_addr;
    logic [7:0] acc_wdata;
    logic acc_write;
    logic acc_state;

    always_comb begin
        acc_addr = pc;
        acc_wdata = 8'h00;
        acc_write = 1'b0;
        acc_state = 1'b1;
        unique case (state)
            ST_OPCODE, ST_ADDR_LO, ST_ADDR_HI: begin
                acc_addr = pc;
            end
            ST_PUSH_HI: begin
                acc_addr = stk - 16'h0001;
                acc_wdata = pc[15:8];
                acc_write = 1'b1;
            end
            ST_PUSH_LO: begin
                acc_addr = stk - 16'h0002;
                acc_wdata = pc[7:0];
                acc_write = 1'b1;
            end
            ST_POP_LO: begin
                acc_addr = stk;
            end
            ST_POP_HI: begin
                acc_addr = stk + 16'h0001;
            end
            ST_DATA_LO: begin
                acc_addr = tgt;
                acc_wdata = reg_l;
                acc_write = dec.kind == KIND_STORE_PAIR;
            end
            ST_DATA_HI: begin
                acc_addr = tgt + 16'h0001;
                acc_wdata = reg_h;
                acc_write = dec.kind == KIND_STORE_PAIR;
            end
            default: begin
                acc_state = 1'b0;
            end
        endcase
    end

    wire logic mem_done = MEM_REQ & MEM_ACK;
    wire logic issue = acc_state & ~MEM_REQ;
    wire pfc_state_e after_insn = run ? ST_OPCODE : ST_IDLE;

    // ****************************************************************
    // Memory request
    // ****************************************************************
    // A request stands until acknowledged; at least one idle cycle separates two
    // requests, trading a little speed for a simple handshake.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            MEM_REQ <= 1'b0;
            MEM_WRITE <= 1'b0;
            MEM_ADDR <= 16'h0000;
            MEM_WDATA <= 8'h00;
        end else if (issue) begin
            MEM_REQ <= 1'b1;
            MEM_WRITE <= acc_write;
            MEM_ADDR <= acc_addr;
            MEM_WDATA <= acc_wdata;
        end else if (mem_done) begin
            MEM_REQ <= 1'b0;
            MEM_WRITE <= 1'b0;
        end
    end

    // ****************************************************************
    // Control and error bits
    // ****************************************************************
    wire logic fault = (state == ST_DECODE) & (dec.kind == KIND_ILLEGAL);

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            run <= 1'b0;
            illegal <= 1'b0;
        end else begin
            if (ctrl_write) begin
                run <= PWDATA[PFC_CTRL_RUN_BIT];
            end
            if (clr_req) begin
                illegal <= 1'b0;
            end
            if (fault) begin
                run <= 1'b0;
                illegal <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Software access to the core registers
    // ****************************************************************
    // Flags are touched only by software; no control-flow instruction
    // has a path into them.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            flags <= PFC_FLAGS_RESET;
        end else if (apb_write & hit_flags) begin
            flags <= PWDATA[3:0];
        end
    end

    // ****************************************************************
    // Instruction sequencer
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state <= ST_IDLE;
            pc <= PFC_PC_RESET;
            stk <= PFC_STK_RESET;
            tgt <= 16'h0000;
            reg_h <= PFC_BYTE_RESET;
            reg_l <= PFC_BYTE_RESET;
            opcode <= PFC_BYTE_RESET;
            count <= 32'h00000000;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (apb_write & hit_pc) begin
                        pc <= PWDATA[15:0];
                    end
                    if (apb_write & hit_stk) begin
                        stk <= PWDATA[15:0];
                    end
                    if (apb_write & hit_pair) begin
                        reg_h <= PWDATA[PFC_PAIR_H_LSB +: 8];
                        reg_l <= PWDATA[7:0];
                    end
                    if (start) begin
                        state <= ST_OPCODE;
                    end
                end
                ST_OPCODE: begin
                    if (mem_done) begin
                        opcode <= MEM_RDATA;
                        pc <= pc + 16'h0001;
                        state <= ST_DECODE;
                    end
                end
                ST_DECODE: begin
                    if (dec.kind == KIND_ILLEGAL) begin
                        state <= ST_IDLE;
                    end else if (dec.operand) begin
                        state <= ST_ADDR_LO;
                    end else if (dec.kind == KIND_PAIR_JUMP) begin
                        pc <= {reg_h, reg_l};
                        count <= count + 32'h00000001;
                        state <= after_insn;
                    end else if (dec.taken) begin
                        state <= ST_POP_LO;
                    end else begin
                        count <= count + 32'h00000001;
                        state <= after_insn;
                    end
                end
                ST_ADDR_LO: begin
                    if (mem_done) begin
                        tgt[7:0] <= MEM_RDATA;
                        pc <= pc + 16'h0001;
                        state <= ST_ADDR_HI;
                    end
                end
                ST_ADDR_HI: begin
                    if (mem_done) begin
                        tgt[15:8] <= MEM_RDATA;
                        pc <= pc + 16'h0001;
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (dec.kind == KIND_JUMP) begin
                        if (dec.taken) begin
                            pc <= tgt;
                        end
                        count <= count + 32'h00000001;
                        state <= after_insn;
                    end else if (dec.kind == KIND_CALL) begin
                        if (dec.taken) begin
                            state <= ST_PUSH_HI;
                        end else begin
                            count <= count + 32'h00000001;
                            state <= after_insn;
                        end
                    end else begin
                        state <= ST_DATA_LO;
                    end
                end
                ST_PUSH_HI: begin
                    if (mem_done) begin
                        state <= ST_PUSH_LO;
                    end
                end
                ST_PUSH_LO: begin
                    if (mem_done) begin
                        stk <= stk - 16'h0002;
                        pc <= tgt;
                        count <= count + 32'h00000001;
                        state <= after_insn;
                    end
                end
                ST_POP_LO: begin
                    if (mem_done) begin
                        tgt[7:0] <= MEM_RDATA;
                        state <= ST_POP_HI;
                    end
                end
                ST_POP_HI: begin
                    if (mem_done) begin
                        pc <= {MEM_RDATA, tgt[7:0]};
                        stk <= stk + 16'h0002;
                        count <= count + 32'h00000001;
                        state <= after_insn;
                    end
                end
                ST_DATA_LO: begin
                    if (mem_done) begin
                        if (dec.kind == KIND_LOAD_PAIR) begin
                            reg_l <= MEM_RDATA;
                        end
                        state <= ST_DATA_HI;
                    end
                end
                ST_DATA_HI: begin
                    if (mem_done) begin
                        if (dec.kind == KIND_LOAD_PAIR) begin
                            reg_h <= MEM_RDATA;
                        end
                        count <= count + 32'h00000001;
                        state <= after_insn;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // pfc_top

/* verification/pfc_mem_model.sv */
`timescale 1ns/100ps
module pfc_mem_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic req,
    input wire logic we,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic ack
);
    logic [7:0] mem [0:65535];
    logic [1:0] wait_cnt;
    initial begin
        rdata = 8'h00;
        ack = 1'b0;
        wait_cnt = 2'h0;
    end
    // Read data is valid only with ack; at other times the line shows the
    // inverse, so a read that ignores ack takes a wrong byte.
    always @(posedge clk) begin
        if (req && ack) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            ack <= 1'b0;
            rdata <= ~rdata;
            wait_cnt <= 2'h0;
        end else if (req && (!slow || wait_cnt == 2'h3)) begin
            ack <= 1'b1;
            rdata <= we ? ~rdata : mem[addr];
        end else begin
            wait_cnt <= req ? wait_cnt + 2'h1 : 2'h0;
        end
    end
endmodule // pfc_mem_model

/* verification/pfc_top_assertions.sv */
`timescale 1ns/100ps
module pfc_top_checker
    import pfc_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [15:0] MEM_ADDR,
    input wire logic [7:0] MEM_WDATA,
    input wire logic MEM_WRITE,
    input wire logic MEM_REQ,
    input wire logic [7:0] MEM_RDATA,
    input wire logic MEM_ACK
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    logic [3:0] flag_copy;
    logic [15:0] last_addr;
    logic last_write;
    wire apb_done = PSEL && PENABLE && PREADY;
    wire mem_done = MEM_REQ && MEM_ACK;
    wire flag_wr = apb_done && PWRITE && !PSLVERR && PADDR == PFC_OFS_FLAGS;
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            flag_copy <= 4'h0;
            last_write <= 1'b0;
        end else begin
            flag_copy <= flag_wr ? PWDATA[3:0] : flag_copy;
            last_write <= mem_done ? MEM_WRITE : last_write;
        end
    end
    always_ff @(posedge CLK) begin
        last_addr <= mem_done ? MEM_ADDR : last_addr;
    end
    apb_answer_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready after setup");
    ready_once_a: assert property (PREADY |=> !PREADY)
        else $error("ready held");
    write_quiet_a: assert property (PREADY && PWRITE |-> PRDATA == 32'h0)
        else $error("data on write");
    unmapped_err_a: assert property (apb_done && PADDR > PFC_OFS_COUNT
        |-> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped accepted");
    flags_kept_a: assert property (apb_done && !PWRITE && PADDR == PFC_OFS_FLAGS
        |-> PRDATA[3:0] == flag_copy) else $error("flags changed");
    req_hold_a: assert property (MEM_REQ && !MEM_ACK
        |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WRITE))
        else $error("request dropped");
    req_gap_a: assert property (mem_done |=> !MEM_REQ)
        else $error("no gap after ack");
    push_pair_a: assert property ($rose(MEM_REQ) && MEM_WRITE && last_write
        |-> MEM_ADDR == last_addr - 16'h1 || MEM_ADDR == last_addr + 16'h1)
        else $error("split write");
    slow_ack_c: cover property (MEM_REQ && !MEM_ACK ##1 mem_done);
    stack_write_c: cover property (mem_done && MEM_WRITE);
    refused_c: cover property (apb_done && PSLVERR);
endmodule // pfc_top_checker

bind pfc_top pfc_top_checker chk_i (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_WRITE(MEM_WRITE),
    .MEM_REQ(MEM_REQ), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK));

/* verification/pfc_top_bench.sv */
`timescale 1ns/100ps
module pfc_top_bench
    import pfc_pkg::*;
;
    logic clk, sys_rst, psel, penable, pwrite, slow;
    logic pready, pslverr, mem_write, mem_req, mem_ack;
    logic [7:0] paddr, mem_wdata, mem_rdata;
    logic [31:0] pwdata, prdata;
    logic [15:0] mem_addr;
    int fail_count = 0;
    int num_checks = 0;
    pfc_top DUT (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_WRITE(mem_write), .MEM_REQ(mem_req),
        .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack));
    pfc_mem_model mem_i (.clk(clk), .slow(slow), .req(mem_req), .we(mem_write),
        .addr(mem_addr), .wdata(mem_wdata), .rdata(mem_rdata), .ack(mem_ack));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask
    // Entered just after a rising edge; the request holds until ready is seen.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 40) fail_count++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp, msg);
    endtask
    task automatic exec(input logic [15:0] pc, input logic [7:0] op, input logic [15:0] t);
        logic [31:0] q;
        logic e;
        int n;
        n = 0;
        mem_i.mem[pc] = op;
        mem_i.mem[pc + 16'h1] = t[7:0];
        mem_i.mem[pc + 16'h2] = t[15:8];
        wr(PFC_OFS_PC, {16'h0, pc});
        wr(PFC_OFS_CTRL, 32'h2);
        do begin
            apb(1'b0, PFC_OFS_STATUS, 32'h0, q, e);
            n++;
        end while (q[PFC_STAT_BUSY_BIT] !== 1'b0 && n < 100);
        if (n >= 100) fail_count++;
    endtask
    task automatic t_jump();
        wr(PFC_OFS_FLAGS, 32'h5);
        exec(16'h0100, PFC_OP_BRANCH_ALWAYS, 16'h1234);
        rdc(PFC_OFS_PC, 32'h1234, "jump pc");
        rdc(PFC_OFS_FLAGS, 32'h5, "jump flags");
    endtask
    // Every condition code of every family, flag set both ways.
    task automatic t_cond();
        int idx [4] = '{1, 0, 3, 2};
        logic [7:0] ops [3] = '{PFC_OP_BRANCH_COND, PFC_OP_CALL_COND, PFC_OP_RETURN_COND};
        logic [3:0] fl;
        logic [15:0] pc, nxt, stk, st, pe, got;
        logic hit;
        for (int k = 0; k < 3; k++) begin
            for (int c = 0; c < 16; c++) begin
                fl = c[0] ? 4'h1 << idx[c[3:2]] : ~(4'h1 << idx[c[3:2]]);
                pc = 16'h1000 + 16'(k * 256 + c * 8);
                hit = c[0] == c[1];
                nxt = (k == 2) ? pc + 16'h1 : pc + 16'h3;
                pe = hit ? ((k == 2) ? {8'h3C, pc[7:0] ^ 8'h5A} : 16'h2468) : nxt;
                stk = (hit && k == 1) ? 16'h7FFE : (hit && k == 2) ? 16'h8002 : 16'h8000;
                st = (hit && k == 1) ? nxt : 16'hEEEE;
                mem_i.mem[16'h7FFE] = 8'hEE;
                mem_i.mem[16'h7FFF] = 8'hEE;
                mem_i.mem[16'h8000] = pc[7:0] ^ 8'h5A;
                mem_i.mem[16'h8001] = 8'h3C;
                wr(PFC_OFS_STK, 32'h8000);
                wr(PFC_OFS_FLAGS, {28'h0, fl});
                exec(pc, ops[k] | {2'b00, c[3:1], 3'b000}, 16'h2468);
                rdc(PFC_OFS_PC, {16'h0, pe}, "cond pc");
                rdc(PFC_OFS_STK, {16'h0, stk}, "cond stack");
                rdc(PFC_OFS_FLAGS, {28'h0, fl}, "cond flags");
                got = {mem_i.mem[16'h7FFF], mem_i.mem[16'h7FFE]};
                chk({16'h0, got}, {16'h0, st}, "stack");
            end
        end
    endtask
    task automatic t_nest();
        slow <= 1'b1;
        wr(PFC_OFS_STK, 32'h9000);
        exec(16'h0200, PFC_OP_CALL_ALWAYS, 16'h0300);
        rdc(PFC_OFS_PC, 32'h0300, "call pc");
        exec(16'h0300, PFC_OP_CALL_ALWAYS, 16'h0400);
        rdc(PFC_OFS_STK, 32'h8FFC, "nest stack");
        exec(16'h0400, PFC_OP_RETURN_ALWAYS, 16'h0);
        rdc(PFC_OFS_PC, 32'h0303, "inner return");
        exec(16'h0303, PFC_OP_RETURN_ALWAYS, 16'h0);
        rdc(PFC_OFS_PC, 32'h0203, "outer return");
        rdc(PFC_OFS_STK, 32'h9000, "return stack");
        slow <= 1'b0;
    endtask
    task automatic t_pair();
        logic [31:0] q;
        logic e;
        mem_i.mem[16'h0600] = 8'h5A;
        mem_i.mem[16'h0601] = 8'hA5;
        exec(16'h0500, PFC_OP_LOAD_PAIR, 16'h0600);
        rdc(PFC_OFS_PAIR, 32'hA55A, "pair load");
        exec(16'h0700, PFC_OP_PAIR_TO_COUNTER, 16'h0);
        rdc(PFC_OFS_PC, 32'hA55A, "pair jump");
        apb(1'b1, PFC_OFS_STATUS, 32'hFF, q, e);
        chk({31'h0, e}, 32'h1, "ro write");
        apb(1'b0, 8'h40, 32'h0, q, e);
        chk({31'h0, e}, 32'h1, "unmapped");
        exec(16'h0800, PFC_OP_STORE_PAIR, 16'h0900);
        chk({16'h0, mem_i.mem[16'h0901], mem_i.mem[16'h0900]}, 32'hA55A, "pair store");
        rdc(PFC_OFS_OPCODE, {24'h0, PFC_OP_STORE_PAIR}, "opcode");
        exec(16'h0A00, 8'h00, 16'h0);
        rdc(PFC_OFS_STATUS, 32'h2, "illegal set");
    endtask
    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        slow = 1'b0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_jump();
        t_cond();
        t_nest();
        t_pair();
        complete_run();
    end
    initial begin
        #200000;
        fail_count++;
        complete_run();
    end
endmodule // pfc_top_bench
